/* rtl/simd_csr_if.sv */
`timescale 1ns/1ps
interface simd_csr_if;
    logic [5:0] setFlags;
    logic wrEn;
    logic [31:0] wrData;
    logic [31:0] value;

    modport owner (input setFlags, input wrEn, input wrData, output value);
    modport user (output setFlags, output wrEn, output wrData, input value);
endinterface

/* rtl/simd_csr_reg.sv */
`timescale 1ns/1ps
module simd_csr_reg
    import simd_fp_exc_pkg::*;
(
    input logic clk, // core clock
    input logic reset, // async, active high
    simd_csr_if.owner csr // flag set and load port
);

    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] loaded;

    always_comb
    begin
        loaded = (ctrl_q & ~CTRL_STATUS_WMASK) | (csr.wrData & CTRL_STATUS_WMASK);
        ctrl_d = csr.wrEn ? loaded : ctrl_q;
        // RULE24 - sticky flags, set wins
        ctrl_d[NUM_CLASSES-1:0] = ctrl_d[NUM_CLASSES-1:0] | csr.setFlags;
    end

    // ==============================================================
    // storage
    // RULE3 - flag and mask storage
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_q <= CTRL_STATUS_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    assign csr.value = ctrl_q;

endmodule

/* rtl/simd_fp_exc_pkg.sv */
package simd_fp_exc_pkg;

    // ==============================================================
    // register map (byte addresses on the plain register port)
    localparam logic [3:0] CTRL_STATUS_OFFSET = 4'h0;
    localparam logic [3:0] CTRL_FOUR_OFFSET = 4'h4;
    localparam logic [3:0] LAST_EVENT_OFFSET = 4'h8;

    // ==============================================================
    // control/status register layout
    localparam int INVALID_OP_FLAG_BIT = 0;
    localparam int DENORMAL_FLAG_BIT = 1;
    localparam int DIV_ZERO_FLAG_BIT = 2;
    localparam int OVERFLOW_FLAG_BIT = 3;
    localparam int UNDERFLOW_FLAG_BIT = 4;
    localparam int INEXACT_FLAG_BIT = 5;
    localparam int DENORMALS_ZERO_BIT = 6;
    localparam int INVALID_OP_MASK_BIT = 7;
    localparam int DENORMAL_MASK_BIT = 8;
    localparam int DIV_ZERO_MASK_BIT = 9;
    localparam int OVERFLOW_MASK_BIT = 10;
    localparam int UNDERFLOW_MASK_BIT = 11;
    localparam int INEXACT_MASK_BIT = 12;
    localparam int FLUSH_ZERO_BIT = 15;
    localparam int NUM_CLASSES = 6;
    localparam logic [31:0] CTRL_STATUS_RESET = 32'h0000_1F80;
    localparam logic [31:0] CTRL_STATUS_WMASK = 32'h0000_FFFF;

    // control register four: os support for the simd fault
    localparam int OS_SIMD_FAULT_SUPPORT_BIT = 10;
    localparam logic [31:0] CTRL_FOUR_RESET = 32'h0000_0000;

    // last-event register layout
    localparam int LAST_FAULT_BIT = 8;
    localparam int LAST_OPCODE_FAULT_BIT = 9;

    // ==============================================================
    // floating-point encodings
    localparam logic [7:0] SP_EXP_ONES = 8'hFF;
    localparam logic [10:0] DP_EXP_ONES = 11'h7FF;
    localparam int SP_QUIET_BIT = 22;
    localparam int DP_QUIET_BIT = 51;
    localparam logic signed [12:0] SP_BIAS = 13'sh007F;
    localparam logic signed [12:0] DP_BIAS = 13'sh03FF;
    localparam logic signed [12:0] INT32_TOP_EXP = 13'sh001F;
    localparam logic signed [12:0] INT64_TOP_EXP = 13'sh003F;
    localparam logic [63:0] SP_INDEFINITE = 64'h0000_0000_FFC0_0000;
    localparam logic [63:0] DP_INDEFINITE = 64'hFFF8_0000_0000_0000;
    localparam logic [63:0] INT32_INDEFINITE = 64'h0000_0000_8000_0000;
    localparam logic [63:0] INT64_INDEFINITE = 64'h8000_0000_0000_0000;
    localparam logic [63:0] SP_ALL_ONES = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] DP_ALL_ONES = 64'hFFFF_FFFF_FFFF_FFFF;
    // flags register image {zero, parity, carry}
    localparam logic [2:0] UNORDERED_FLAGS = 3'h7;

    // ==============================================================
    // compare predicates
    localparam logic [2:0] PRED_EQ = 3'h0;
    localparam logic [2:0] PRED_LT = 3'h1;
    localparam logic [2:0] PRED_LE = 3'h2;
    localparam logic [2:0] PRED_UNORD = 3'h3;
    localparam logic [2:0] PRED_NEQ = 3'h4;
    localparam logic [2:0] PRED_NLT = 3'h5;
    localparam logic [2:0] PRED_NLE = 3'h6;

    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SQRT, OP_MAXMIN,
        OP_CMP, OP_COMI, OP_CVT_FP, OP_CVT_INT, OP_OTHER
    } opkind_t;

endpackage

/* rtl/simd_fp_exception_unit.sv */
`timescale 1ns/1ps
// What this block does
// RULE1 - six exception classes are recognised
// RULE2 - exceptions raised exactly at instruction completion
// RULE3 - one flag, one mask per class
// RULE4 - load/restore write; store/save read back
// RULE5 - unmasked with os support raises simd fault
// RULE6 - without os support raise invalid-opcode fault
// RULE7 - invalid flag bit 0, mask bit 7
// RULE8 - masked default value overwrites destination register
// RULE9 - arithmetic signaling NaN returns quieted NaN
// RULE10 - square root: quieted NaN or indefinite
// RULE11 - max/min with NaN return second source
// RULE12 - compares with NaN give zero/ones mask
// RULE13 - precision conversion quiets signaling NaN
// RULE14 - flag compares with NaN report unordered
// RULE15 - infinity/zero misuse returns NaN indefinite
// RULE16 - bad float-to-integer returns integer indefinite
// RULE17 - unmasked invalid leaves destination untouched
// RULE18 - quiet NaN invalid only for listed compares
// RULE19 - invalid handling ignores flush and denormal modes
// RULE20 - denormal flag bit 1, mask bit 8
// RULE21 - divide-by-zero flag bit 2, mask bit 9
// RULE22 - overflow flag bit 3, mask bit 10
// RULE23 - underflow flag bit 4, mask bit 11
// RULE24 - flags sticky until software writes register
module simd_fp_exception_unit
    import simd_fp_exc_pkg::*;
(
    input logic clk, // core clock, 10 MHz
    input logic reset, // async, active high
    input logic [3:0] regAddr, // register byte address
    input logic [31:0] regWrData, // register write data
    input logic regWr, // register write strobe
    input logic regRd, // register read strobe
    output logic [31:0] regRdData, // read data, cycle after strobe
    input logic opValid, // one lane of an instruction completes
    input opkind_t opKind, // operation class of the lane
    input logic [2:0] cmpPred, // compare predicate
    input logic isDouble, // source format is double
    input logic intWide, // integer conversion target is 64-bit
    input logic [63:0] srcA, // first source operand
    input logic [63:0] srcB, // second source operand
    input logic [63:0] dpResult, // datapath result when no override
    input logic [2:0] dpFlags, // datapath flags image {z,p,c}
    input logic [4:0] otherCond, // {inexact,underflow,overflow,divzero,denormal}
    input logic ctrlLoad, // load or full-state restore instruction
    input logic [31:0] ctrlLoadData, // value loaded into control/status
    output logic [31:0] ctrlStoreValue, // image for store or full-state save
    output logic doneValid, // lane finished, one-cycle pulse
    output logic destWrite, // destination register write enable
    output logic [63:0] destValue, // destination value
    output logic flagsWrite, // flags register write enable
    output logic [2:0] flagsValue, // flags image {z,p,c}
    output logic simdFpFault, // simd floating-point fault pulse
    output logic invalidOpcodeFault // invalid-opcode fault pulse
);

    // ==============================================================
    // operand classification
    function automatic logic isNanF(input logic [63:0] x, input logic dbl);
        if (dbl)
            isNanF = (x[62:52] == DP_EXP_ONES) && (x[51:0] != 52'h0);
        else
            isNanF = (x[30:23] == SP_EXP_ONES) && (x[22:0] != 23'h0);
    endfunction

    function automatic logic isSnanF(input logic [63:0] x, input logic dbl);
        if (dbl)
            isSnanF = isNanF(x, dbl) && !x[DP_QUIET_BIT];
        else
            isSnanF = isNanF(x, dbl) && !x[SP_QUIET_BIT];
    endfunction

    function automatic logic isInfF(input logic [63:0] x, input logic dbl);
        if (dbl)
            isInfF = (x[62:52] == DP_EXP_ONES) && (x[51:0] == 52'h0);
        else
            isInfF = (x[30:23] == SP_EXP_ONES) && (x[22:0] == 23'h0);
    endfunction

    function automatic logic isZeroF(input logic [63:0] x, input logic dbl);
        isZeroF = dbl ? (x[62:0] == 63'h0) : (x[30:0] == 31'h0);
    endfunction

    function automatic logic signF(input logic [63:0] x, input logic dbl);
        signF = dbl ? x[63] : x[31];
    endfunction

    // quiet a NaN in its own format
    function automatic logic [63:0] quietF(input logic [63:0] x, input logic dbl);
        quietF = dbl ? (x | (64'h1 << DP_QUIET_BIT)) : {32'h0, x[31:0] | (32'h1 << SP_QUIET_BIT)};
    endfunction

    // quiet a NaN while changing format; payload keeps its top bits
    function automatic logic [63:0] quietCvtF(input logic [63:0] x, input logic dbl);
        quietCvtF = dbl ? {32'h0, x[63], SP_EXP_ONES, 1'b1, x[50:29]}
            : {x[31], DP_EXP_ONES, 1'b1, x[21:0], 29'h0};
    endfunction

    // magnitude too large for the integer target; exactly the most
    // negative integer still fits
    function automatic logic outOfRangeF(input logic [63:0] x, input logic dbl,
                                         input logic wide);
        logic signed [12:0] e;
        logic signed [12:0] top;
        logic fracZero;
        if (dbl)
            e = $signed({2'b00, x[62:52]}) - DP_BIAS;
        else
            e = $signed({5'b00000, x[30:23]}) - SP_BIAS;
        top = wide ? INT64_TOP_EXP : INT32_TOP_EXP;
        fracZero = dbl ? (x[51:0] == 52'h0) : (x[22:0] == 23'h0);
        if (e > top)
            outOfRangeF = 1'b1;
        else if (e == top)
            outOfRangeF = !(signF(x, dbl) && fracZero);
        else
            outOfRangeF = 1'b0;
    endfunction

    // ==============================================================
    // invalid-operation detection and masked default
    logic aNan;
    logic bNan;
    logic aSnan;
    logic bSnan;
    logic aInf;
    logic bInf;
    logic aZero;
    logic bZero;
    logic invalidHit;
    logic useOverride;
    logic [63:0] overrideValue;
    logic [2:0] cmpFlags;
    logic [63:0] indefinite;
    logic [63:0] snanQuieted;
    logic arithBad;

    // RULE19 - no flush or denormal mode input here
    assign aNan = isNanF(srcA, isDouble);
    assign bNan = isNanF(srcB, isDouble);
    assign aSnan = isSnanF(srcA, isDouble);
    assign bSnan = isSnanF(srcB, isDouble);
    assign aInf = isInfF(srcA, isDouble);
    assign bInf = isInfF(srcB, isDouble);
    assign aZero = isZeroF(srcA, isDouble);
    assign bZero = isZeroF(srcB, isDouble);
    assign indefinite = isDouble ? DP_INDEFINITE : SP_INDEFINITE;
    // the first signaling source is the one returned
    assign snanQuieted = aSnan ? quietF(srcA, isDouble) : quietF(srcB, isDouble);
    // RULE15 - infinity and zero misuse
    assign arithBad = (opKind == OP_MUL) ? ((aInf && bZero) || (aZero && bInf))
        : (opKind == OP_DIV) ? ((aZero && bZero) || (aInf && bInf))
        : (aInf && bInf && (signF(srcA, isDouble) ^ signF(srcB, isDouble) ^ (opKind == OP_SUB)));

    always_comb
    begin
        invalidHit = 1'b0;
        useOverride = 1'b0;
        overrideValue = dpResult;
        cmpFlags = dpFlags;
        case (opKind)
            OP_ADD, OP_SUB, OP_MUL, OP_DIV:
            begin
                // RULE9 - signaling NaN quieted
                invalidHit = aSnan || bSnan || arithBad;
                useOverride = invalidHit;
                overrideValue = (aSnan || bSnan) ? snanQuieted : indefinite;
            end
            OP_SQRT:
            begin
                // RULE10 - square root responses
                invalidHit = aSnan || (!aNan && !aZero && signF(srcA, isDouble));
                useOverride = invalidHit;
                overrideValue = aSnan ? quietF(srcA, isDouble) : indefinite;
            end
            OP_MAXMIN:
            begin
                // RULE11 - second source returned
                invalidHit = aNan || bNan;
                useOverride = invalidHit;
                overrideValue = srcB;
            end
            OP_CMP:
            begin
                if (aNan || bNan)
                begin
                    // RULE18 - quiet NaN ordering predicates
                    invalidHit = aSnan || bSnan || (cmpPred == PRED_LT)
                        || (cmpPred == PRED_LE) || (cmpPred == PRED_NLT)
                        || (cmpPred == PRED_NLE);
                    useOverride = 1'b1;
                    // RULE12 - unordered compare mask
                    if ((cmpPred == PRED_NEQ) || (cmpPred == PRED_UNORD)
                        || (cmpPred == PRED_NLT) || (cmpPred == PRED_NLE))
                        overrideValue = isDouble ? DP_ALL_ONES : SP_ALL_ONES;
                    else
                        overrideValue = 64'h0;
                end
            end
            OP_COMI:
            begin
                // RULE14 - unordered flags image
                invalidHit = aNan || bNan;
                cmpFlags = invalidHit ? UNORDERED_FLAGS : dpFlags;
            end
            OP_CVT_FP:
            begin
                // RULE13 - quieted in destination format
                invalidHit = aSnan;
                useOverride = aSnan;
                overrideValue = quietCvtF(srcA, isDouble);
            end
            OP_CVT_INT:
            begin
                // RULE16 - integer indefinite
                invalidHit = aNan || aInf || outOfRangeF(srcA, isDouble, intWide);
                useOverride = invalidHit;
                overrideValue = intWide ? INT64_INDEFINITE : INT32_INDEFINITE;
            end
            default:
            begin
                invalidHit = 1'b0;
            end
        endcase
    end

    // ==============================================================
    // dispatch
    simd_csr_if csr ();
    logic [31:0] ctrlFour_q;
    logic [5:0] condVec;
    logic [5:0] maskVec;
    logic [5:0] unmasked;
    logic osSupport;
    logic takeFault;

    // RULE1 - six classes in one vector
    assign condVec = {otherCond[4], otherCond[3], otherCond[2], otherCond[1],
                      otherCond[0], invalidHit};
    // RULE7 - invalid mask bit
    // RULE20 - denormal mask bit
    // RULE21 - divide-by-zero mask bit
    // RULE22 - overflow mask bit
    // RULE23 - underflow mask bit
    assign maskVec = {csr.value[INEXACT_MASK_BIT], csr.value[UNDERFLOW_MASK_BIT],
                      csr.value[OVERFLOW_MASK_BIT], csr.value[DIV_ZERO_MASK_BIT],
                      csr.value[DENORMAL_MASK_BIT], csr.value[INVALID_OP_MASK_BIT]};
    assign unmasked = condVec & ~maskVec;
    assign osSupport = ctrlFour_q[OS_SIMD_FAULT_SUPPORT_BIT];
    assign takeFault = opValid && (unmasked != 6'h0);

    // RULE7 - invalid flag at bit 0 raised
    assign csr.setFlags = opValid ? condVec : 6'h0;
    // RULE4 - load instruction wins over a bus write
    assign csr.wrEn = ctrlLoad || (regWr && (regAddr == CTRL_STATUS_OFFSET));
    assign csr.wrData = ctrlLoad ? ctrlLoadData : regWrData;

    simd_csr_reg csrReg (
        .clk(clk),
        .reset(reset),
        .csr(csr)
    );

    // RULE4 - store/save image
    assign ctrlStoreValue = csr.value;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctrlFour_q <= CTRL_FOUR_RESET;
        end
        else if (regWr && (regAddr == CTRL_FOUR_OFFSET))
        begin
            ctrlFour_q <= regWrData;
        end
    end

    // RULE2 - outputs registered, the cycle after the lane completes
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            doneValid <= 1'b0;
            destWrite <= 1'b0;
            flagsWrite <= 1'b0;
            simdFpFault <= 1'b0;
            invalidOpcodeFault <= 1'b0;
        end
        else
        begin
            doneValid <= opValid;
            // RULE17 - no write on a fault
            // RULE8 - masked default overwrites
            destWrite <= opValid && !takeFault && (opKind != OP_COMI);
            flagsWrite <= opValid && !takeFault && (opKind == OP_COMI);
            // RULE5 - simd fault with os support
            simdFpFault <= takeFault && osSupport;
            // RULE6 - invalid-opcode fault otherwise
            invalidOpcodeFault <= takeFault && !osSupport;
        end
    end

    // data held while no lane completes
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            destValue <= 64'h0;
            flagsValue <= 3'h0;
        end
        else if (opValid)
        begin
            destValue <= useOverride ? overrideValue : dpResult;
            flagsValue <= cmpFlags;
        end
    end

    // ==============================================================
    // register read port
    logic [9:0] lastEvent_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            lastEvent_q <= 10'h0;
        end
        else if (opValid && (condVec != 6'h0))
        begin
            lastEvent_q <= {takeFault && !osSupport, takeFault && osSupport, 2'b00, condVec};
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            regRdData <= 32'h0;
        end
        else if (!regRd)
        begin
            regRdData <= 32'h0;
        end
        else if (regAddr == CTRL_STATUS_OFFSET)
        begin
            regRdData <= csr.value;
        end
        else if (regAddr == CTRL_FOUR_OFFSET)
        begin
            regRdData <= ctrlFour_q;
        end
        else if (regAddr == LAST_EVENT_OFFSET)
        begin
            regRdData <= {22'h0, lastEvent_q};
        end
        else
        begin
            regRdData <= 32'h0;
        end
    end

endmodule

/* testbench/simd_fp_exc_asserts.sv */
`timescale 1ns/1ps
module simd_fp_exc_asserts
    import simd_fp_exc_pkg::*;
(
    input logic clk, // clock
    input logic reset, // reset
    input logic [3:0] regAddr, // address
    input logic [31:0] regWrData, // write data
    input logic regWr, // write strobe
    input logic regRd, // read strobe
    input logic [31:0] regRdData, // read data
    input logic opValid, // lane issue
    input opkind_t opKind, // lane class
    input logic ctrlLoad, // load instr
    input logic [31:0] ctrlStoreValue, // csr image
    input logic doneValid, // lane done
    input logic destWrite, // dest write
    input logic flagsWrite, // flags write
    input logic simdFpFault, // simd fault
    input logic invalidOpcodeFault // opcode fault
);
    // ====================
    // shadow of the os support bit, so fault routing can be judged from the ports
    logic osBit_q;
    logic wipe;
    assign wipe = (regWr && regAddr == CTRL_STATUS_OFFSET) || ctrlLoad;
    always_ff @(posedge clk or posedge reset)
        if (reset)
            osBit_q <= 1'b0;
        else if (regWr && regAddr == CTRL_FOUR_OFFSET)
            osBit_q <= regWrData[OS_SIMD_FAULT_SUPPORT_BIT];

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_done_follows: assert property (opValid |=> doneValid)
        else $error("lane not finished next cycle");
    a_done_cause: assert property (doneValid |-> $past(opValid))
        else $error("completion without a lane");
    a_fault_nowrite: assert property ((simdFpFault || invalidOpcodeFault) |->
        doneValid && !destWrite && !flagsWrite) else $error("fault wrote a result");
    a_fault_os: assert property (simdFpFault |-> $past(osBit_q) && !invalidOpcodeFault)
        else $error("simd fault without os support");
    a_opcode_noos: assert property (invalidOpcodeFault |-> !$past(osBit_q))
        else $error("opcode fault with os support");
    a_flag_sticky: assert property ($fell(ctrlStoreValue[INVALID_OP_FLAG_BIT]) |->
        $past(wipe) || $past(wipe, 2)) else $error("flag cleared by itself");
    a_upper_zero: assert property (ctrlStoreValue[31:16] == 16'h0000)
        else $error("csr upper half not zero");
    a_flags_comi: assert property (flagsWrite |-> $past(opValid && opKind == OP_COMI))
        else $error("flags written by other op");
    a_read_stands: assert property (regRdData != 32'h0 |-> $past(regRd))
        else $error("read data outside its cycle");

    cover property (simdFpFault);
    cover property (invalidOpcodeFault);
    cover property (flagsWrite);
endmodule

bind simd_fp_exception_unit simd_fp_exc_asserts chk (.clk, .reset, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .opValid, .opKind, .ctrlLoad, .ctrlStoreValue, .doneValid,
    .destWrite, .flagsWrite, .simdFpFault, .invalidOpcodeFault);

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import simd_fp_exc_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic opValid = 1'b0;
    opkind_t opKind = OP_OTHER;
    logic [2:0] cmpPred = 3'h0;
    logic isDouble = 1'b0;
    logic intWide = 1'b0;
    logic [63:0] srcA = 64'h0;
    logic [63:0] srcB = 64'h0;
    logic [63:0] dpResult = 64'h1234_5678;
    logic [2:0] dpFlags = 3'h0;
    logic [4:0] otherCond = 5'h00;
    logic ctrlLoad = 1'b0;
    logic [31:0] ctrlLoadData = 32'h0;
    logic [31:0] regRdData, ctrlStoreValue;
    logic doneValid, destWrite, flagsWrite, simdFpFault, invalidOpcodeFault;
    logic [63:0] destValue;
    logic [2:0] flagsValue;
    int errCount = 0;
    int checks = 0;

    simd_fp_exception_unit uut (.clk, .reset, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .opValid, .opKind, .cmpPred, .isDouble, .intWide, .srcA, .srcB,
        .dpResult, .dpFlags, .otherCond, .ctrlLoad, .ctrlLoadData, .ctrlStoreValue,
        .doneValid, .destWrite, .destValue, .flagsWrite, .flagsValue, .simdFpFault,
        .invalidOpcodeFault);

    always #50 clk = ~clk;

    // ====================
    // bus and lane drivers
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk({32'h0, regRdData}, {32'h0, e});
    endtask

    task automatic ld(input logic [31:0] d);
        @(posedge clk);
        ctrlLoad <= 1'b1;
        ctrlLoadData <= d;
        @(posedge clk);
        ctrlLoad <= 1'b0;
    endtask

    task automatic op(input opkind_t k, input logic [2:0] p, input logic d,
        input logic [63:0] a, input logic [63:0] b, input logic [4:0] c);
        @(posedge clk);
        opValid <= 1'b1;
        opKind <= k;
        cmpPred <= p;
        isDouble <= d;
        srcA <= a;
        srcB <= b;
        otherCond <= c;
        @(posedge clk);
        opValid <= 1'b0;
        otherCond <= 5'h00;
        #1;
    endtask

    task automatic res(input opkind_t k, input logic [2:0] p, input logic d,
        input logic [63:0] a, input logic [63:0] b, input logic [63:0] e);
        op(k, p, d, a, b, 5'h00);
        outs(4'hC);
        chk(destValue, e);
    endtask

    task automatic outs(input logic [3:0] e);
        chk({60'h0, doneValid, destWrite, simdFpFault, invalidOpcodeFault}, {60'h0, e});
    endtask

    // ====================
    // scenarios
    task automatic t_reset();
        rd(CTRL_STATUS_OFFSET, CTRL_STATUS_RESET);
        rd(CTRL_FOUR_OFFSET, 32'h0);
        rd(4'hC, 32'h0);
        chk({32'h0, ctrlStoreValue}, {32'h0, CTRL_STATUS_RESET});
        $display("reset values done");
    endtask

    task automatic t_masked();
        res(OP_ADD, 3'h0, 1'b0, 64'h7F80_0000, 64'hFF80_0000, SP_INDEFINITE);
        res(OP_SUB, 3'h0, 1'b0, 64'h7F80_0000, 64'h7F80_0000, SP_INDEFINITE);
        res(OP_MUL, 3'h0, 1'b1, 64'h7FF0_0000_0000_0000, 64'h0, DP_INDEFINITE);
        res(OP_DIV, 3'h0, 1'b0, 64'h0, 64'h0, SP_INDEFINITE);
        res(OP_ADD, 3'h0, 1'b0, 64'h7F80_0001, 64'h3F80_0000, 64'h7FC0_0001);
        res(OP_SQRT, 3'h0, 1'b0, 64'hBF80_0000, 64'hBF80_0000, SP_INDEFINITE);
        res(OP_SQRT, 3'h0, 1'b0, 64'h7F80_0001, 64'h7F80_0001, 64'h7FC0_0001);
        res(OP_MAXMIN, 3'h0, 1'b0, 64'h7FC0_0000, 64'h3F80_0000, 64'h3F80_0000);
        res(OP_CMP, PRED_NEQ, 1'b0, 64'h7FC0_0000, 64'h3F80_0000, SP_ALL_ONES);
        res(OP_CMP, PRED_EQ, 1'b0, 64'h7FC0_0000, 64'h3F80_0000, 64'h0);
        res(OP_CVT_INT, 3'h0, 1'b0, 64'h7F80_0000, 64'h0, INT32_INDEFINITE);
        intWide <= 1'b1;
        res(OP_CVT_INT, 3'h0, 1'b1, 64'h43E0_0000_0000_0000, 64'h0, INT64_INDEFINITE);
        intWide <= 1'b0;
        res(OP_CVT_FP, 3'h0, 1'b0, 64'h7F80_0001, 64'h0, 64'h7FF8_0000_2000_0000);
        op(OP_COMI, 3'h0, 1'b0, 64'h7FC0_0000, 64'h0, 5'h00);
        chk({62'h0, flagsWrite, destWrite}, 64'h2);
        chk({61'h0, flagsValue}, {61'h0, UNORDERED_FLAGS});
        rd(CTRL_STATUS_OFFSET, 32'h1F81);
        $display("masked responses done");
    endtask

    task automatic t_quiet();
        wr(CTRL_STATUS_OFFSET, 32'h9FC0);
        res(OP_ADD, 3'h0, 1'b0, 64'h7FC0_0000, 64'h3F80_0000, 64'h1234_5678);
        rd(CTRL_STATUS_OFFSET, 32'h9FC0);
        op(OP_CMP, PRED_LT, 1'b0, 64'h7FC0_0000, 64'h3F80_0000, 5'h00);
        rd(CTRL_STATUS_OFFSET, 32'h9FC1);
        wr(CTRL_STATUS_OFFSET, 32'h9FC0);
        res(OP_ADD, 3'h0, 1'b0, 64'h7F80_0000, 64'hFF80_0000, SP_INDEFINITE);
        rd(CTRL_STATUS_OFFSET, 32'h9FC1);
        $display("quiet nan done");
    endtask

    task automatic t_unmask();
        logic [31:0] m;
        wr(CTRL_FOUR_OFFSET, 32'h0400);
        wr(CTRL_STATUS_OFFSET, 32'h1F00);
        op(OP_ADD, 3'h0, 1'b0, 64'h7F80_0000, 64'hFF80_0000, 5'h00);
        outs(4'hA);
        wr(CTRL_FOUR_OFFSET, 32'h0);
        op(OP_ADD, 3'h0, 1'b0, 64'h7F80_0000, 64'hFF80_0000, 5'h00);
        outs(4'h9);
        rd(CTRL_STATUS_OFFSET, 32'h1F01);
        // each other class in turn: only its own mask is open
        for (int i = 1; i < 6; i++)
        begin
            m = CTRL_STATUS_RESET ^ (32'h1 << (7 + i));
            ld(m);
            op(OP_OTHER, 3'h0, 1'b0, 64'h0, 64'h0, 5'h01 << (i - 1));
            outs(4'h9);
            rd(CTRL_STATUS_OFFSET, m | (32'h1 << i));
        end
        ld(CTRL_STATUS_RESET);
        op(OP_OTHER, 3'h0, 1'b0, 64'h0, 64'h0, 5'h10);
        outs(4'hC);
        rd(LAST_EVENT_OFFSET, 32'h20);
        $display("unmasked faults done");
    endtask

    task automatic closeOut();
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_masked();
        t_quiet();
        t_unmask();
        closeOut();
    end
endmodule
